// >>> logic/clock_sel_defines.vh
`ifndef CLOCK_SEL_DEFINES_VH
`define CLOCK_SEL_DEFINES_VH

// ****************************************
// source-choice encodings
// ****************************************
`define SRC_CHOICE_W 2
`define SRC_HF_OSC 2'h0
`define SRC_EXT_CLOCK 2'h1
`define SRC_LF_OSC 2'h2
`define SRC_SPARE 2'h3

// ****************************************
// divide-ratio field
// ****************************************
`define DIV_RATIO_W 3
`define HALF_COUNT_W 8

// ****************************************
// reset values
// ****************************************
`define SRC_CHOICE_RESET 2'h0
`define DIV_RATIO_RESET 3'h0

// ****************************************
// synchroniser depth
// ****************************************
`define SYNC_STAGES 2

`endif

// >>> logic/level_synchronizer.v
`timescale 1ns/100ps

// two flip-flop synchroniser for asynchronous levels
module level_synchronizer #(
  parameter WIDTH = 3
) (
  input wire clock,
  input wire srst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clock)
  begin
    if (srst)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // level_synchronizer

// >>> logic/system_clock_selector.v
// Overview of operation
// - external clock drives the system clock only when source choice is 01b.
// - clock-select register holds source choice and divide ratio fields.
// - external clock is resynchronised for peripherals when not the system source.
// - source may change while running; software picks only enabled, settled sources.
// - a new divide ratio is accepted at any time, with no precondition.
// - internal oscillators usable right after enabling, no added start-up wait.
`timescale 1ns/100ps
`include "clock_sel_defines.vh"

module system_clock_selector #(
  parameter DIV_W = `DIV_RATIO_W,
  parameter CNT_W = `HALF_COUNT_W
) (
  input wire clock,
  input wire srst,
  input wire hf_osc_in,
  input wire lf_osc_in,
  input wire ext_clock_in,
  input wire cfg_write,
  input wire [`SRC_CHOICE_W-1:0] cfg_source_choice,
  input wire [DIV_W-1:0] cfg_divide_ratio,
  output reg system_clock_out,
  output reg ext_clock_sync_out,
  output reg ext_sync_active,
  output reg [`SRC_CHOICE_W-1:0] active_source,
  output reg [DIV_W-1:0] active_divide,
  output reg switch_pending
);

  // ****************************************
  // helper functions
  // ****************************************

  // level of the oscillator named by a source choice
  function pick_level;
    input [`SRC_CHOICE_W-1:0] choice;
    input [2:0] levels;
    begin
      case (choice)
        `SRC_EXT_CLOCK: pick_level = levels[1];
        `SRC_LF_OSC: pick_level = levels[2];
        default: pick_level = levels[0];
      endcase
    end
  endfunction

  // source edges per half period, minus one
  function [CNT_W-1:0] half_target;
    input [DIV_W-1:0] ratio;
    reg [CNT_W:0] span;
    begin
      span = {{CNT_W{1'b0}}, 1'b1} << ratio;
      half_target = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // count advanced by one source edge
  function [CNT_W-1:0] count_step;
    input [CNT_W-1:0] count;
    begin
      count_step = count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // ****************************************
  // oscillator synchronisers
  // ****************************************

  // one synchroniser lane per clock source
  localparam OSC_COUNT = 3;

  wire [OSC_COUNT-1:0] osc_sync;

  level_synchronizer #(
    .WIDTH(OSC_COUNT)
  ) osc_sync_inst (
    .clock(clock),
    .srst(srst),
    .async_in({lf_osc_in, ext_clock_in, hf_osc_in}),
    .sync_out(osc_sync)
  );

  // ****************************************
  // clock-select register
  // ****************************************

  reg [`SRC_CHOICE_W+DIV_W-1:0] clock_source_select_reg;
  reg [`SRC_CHOICE_W+DIV_W-1:0] clock_source_select_next;
  wire [`SRC_CHOICE_W-1:0] source_choice_field;
  wire [DIV_W-1:0] divide_ratio_field;

  // firmware strobe loads both fields, no conditions
  always @*
  begin
    clock_source_select_next = clock_source_select_reg;
    if (cfg_write)
    begin
      clock_source_select_next = {cfg_source_choice, cfg_divide_ratio};
    end
  end

  // register holds until the next strobe
  always @(posedge clock)
  begin
    if (srst)
    begin
      clock_source_select_reg <= {`SRC_CHOICE_RESET, `DIV_RATIO_RESET};
    end
    else
    begin
      clock_source_select_reg <= clock_source_select_next;
    end
  end

  // field views of the register
  assign source_choice_field = clock_source_select_reg[`SRC_CHOICE_W+DIV_W-1:DIV_W];
  assign divide_ratio_field = clock_source_select_reg[DIV_W-1:0];

  // ****************************************
  // edge detection on the active source
  // ****************************************

  reg prev_level_reg;
  reg [CNT_W-1:0] edge_count_reg;
  wire src_level;
  wire src_edge;
  wire src_rise;
  wire [CNT_W-1:0] target;
  wire new_setting;
  wire high_done;
  wire at_boundary;
  wire ext_is_system;

  assign src_level = pick_level(active_source, osc_sync);
  assign src_edge = src_level ^ prev_level_reg;
  assign src_rise = src_level & ~prev_level_reg;
  assign target = half_target(active_divide);
  assign new_setting = clock_source_select_reg != {active_source, active_divide};
  // high phase has seen 2^ratio source edges
  assign high_done = edge_count_reg == target;
  // low phase complete on a rising source edge: end of a full period
  assign at_boundary = (edge_count_reg >= target) && src_rise;
  assign ext_is_system = active_source == `SRC_EXT_CLOCK;

  // ****************************************
  // divider and boundary switch
  // ****************************************

  // output toggles every 2^ratio source edges; rises only on a rising edge
  always @(posedge clock)
  begin
    if (srst)
    begin
      system_clock_out <= 1'b0;
      edge_count_reg <= {CNT_W{1'b0}};
      prev_level_reg <= 1'b0;
      active_source <= `SRC_CHOICE_RESET;
      active_divide <= `DIV_RATIO_RESET;
    end
    else
    begin
      prev_level_reg <= src_level;
      if (src_edge)
      begin
        if (system_clock_out)
        begin
          if (high_done)
          begin
            system_clock_out <= 1'b0;
            edge_count_reg <= {CNT_W{1'b0}};
          end
          else
          begin
            edge_count_reg <= count_step(edge_count_reg);
          end
        end
        else if (at_boundary)
        begin
          // end of a full period: the only place a change takes effect
          if (new_setting)
          begin
            active_source <= source_choice_field;
            active_divide <= divide_ratio_field;
            edge_count_reg <= {CNT_W{1'b0}};
            prev_level_reg <= pick_level(source_choice_field, osc_sync);
          end
          else
          begin
            system_clock_out <= 1'b1;
            edge_count_reg <= {CNT_W{1'b0}};
          end
        end
        else if (edge_count_reg < target)
        begin
          edge_count_reg <= count_step(edge_count_reg);
        end
      end
    end
  end

  // ****************************************
  // status and peripheral clock outputs
  // ****************************************

  // resynchronised external level for timers and counter array
  always @(posedge clock)
  begin
    if (srst)
    begin
      ext_clock_sync_out <= 1'b0;
      ext_sync_active <= 1'b1;
      switch_pending <= 1'b0;
    end
    else
    begin
      ext_clock_sync_out <= osc_sync[1];
      ext_sync_active <= ~ext_is_system;
      switch_pending <= new_setting;
    end
  end

endmodule // system_clock_selector

// >>> verification/clock_selector_asserts.sv
`timescale 1ns/100ps
// ****
// port checks
// ****
module clock_selector_asserts #(parameter DIV_W = 3) (
  input logic clock,
  input logic srst,
  input logic ext_clock_in,
  input logic system_clock_out,
  input logic ext_clock_sync_out,
  input logic ext_sync_active,
  input logic [1:0] active_source,
  input logic [DIV_W-1:0] active_divide,
  input logic switch_pending
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  // selection, sync path, phases
  AST_EXT_SEL: assert property (
    active_source == 2'h1 && $stable(active_source) |-> !ext_sync_active) else $error("a");
  AST_INT_SEL: assert property (
    active_source != 2'h1 && $stable(active_source) |-> ext_sync_active) else $error("b");
  AST_SYNC_PATH: assert property (
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3) && ext_sync_active
    && $past(ext_sync_active, 3) |-> ext_clock_sync_out == $past(ext_clock_in, 3))
    else $error("c");
  AST_HIGH_MIN: assert property ($rose(system_clock_out) |=> system_clock_out)
    else $error("d");
  AST_LOW_MIN: assert property ($fell(system_clock_out) |=> !system_clock_out)
    else $error("e");
  AST_AT_LOW: assert property (
    !$stable({active_source, active_divide}) |-> !system_clock_out) else $error("f");
  AST_PEND_BOUND: assert property (
    switch_pending |-> ##[1:1000] !switch_pending) else $error("g");
  AST_RESET_VALS: assert property ($fell(srst) |-> !system_clock_out
    && ext_sync_active && active_source == 2'h0 && active_divide == '0 && !switch_pending)
    else $error("h");
  COV_EXT: cover property (active_source == 2'h1 && !switch_pending);
  COV_DIV7: cover property ($rose(system_clock_out) && &active_divide);
  COV_PEND: cover property ($fell(switch_pending));
endmodule // clock_selector_asserts

bind system_clock_selector clock_selector_asserts #(.DIV_W(DIV_W))
  u_clock_selector_asserts (.*);

// >>> verification/osc_sources.sv
`timescale 1ns/100ps
// ****
// free oscillators and external clock
// ****
module osc_sources (
  output logic hf,
  output logic lf,
  output logic ext
);
  // sources run from time zero at three rates
  initial {hf, lf, ext} = 3'h0;
  always #30 hf = ~hf;
  always #110 lf = ~lf;
  always #50 ext = ~ext;
endmodule // osc_sources

// >>> verification/test_system_clock_selector.sv
`timescale 1ns/100ps
// ****
// selector bench
// ****
module test_system_clock_selector;
  logic clock = 1'h0, srst = 1'h1, cfg_write = 1'h0;
  logic [1:0] src = 2'h0;
  logic [2:0] div = 3'h0;
  logic hf, lf, ext, sys, exs, ea, pend;
  logic [1:0] asrc;
  logic [2:0] adiv;
  int n_errors = 0, cmp_count = 0, cyc = 0, len;
  logic [2:0] ext_hist = 3'h0;
  // cfg word beside its high phase length in clock cycles
  logic [13:0] rows [5] = '{{5'h01, 9'h006}, {5'h08, 9'h005}, {5'h12, 9'h02c},
    {5'h1b, 9'h018}, {5'h07, 9'h180}};
  system_clock_selector u_system_clock_selector (.clock(clock), .srst(srst),
    .hf_osc_in(hf), .lf_osc_in(lf), .ext_clock_in(ext), .cfg_write(cfg_write),
    .cfg_source_choice(src), .cfg_divide_ratio(div), .system_clock_out(sys),
    .ext_clock_sync_out(exs), .ext_sync_active(ea), .active_source(asrc),
    .active_divide(adiv), .switch_pending(pend));
  osc_sources u_osc_sources (.hf(hf), .lf(lf), .ext(ext));
  always #5 clock = ~clock;
  // pin history for the resynchronised external level
  always @(posedge clock) ext_hist <= {ext_hist[1:0], ext};
  // hang limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic write_cfg(input logic [4:0] v);
    @(negedge clock);
    {src, div, cfg_write} = {v, 1'h1};
    @(negedge clock);
    cfg_write = 1'h0;
  endtask
  task automatic settle;
    int k;
    repeat (3) @(negedge clock);
    for (k = 0; k < 1500 && pend !== 1'h0; k++) @(negedge clock);
  endtask
  task automatic run_while(input logic lvl, output int n);
    for (n = 0; sys === lvl && n < 2000; n++) @(negedge clock);
  endtask
  task automatic do_reset;
    @(negedge clock);
    srst = 1'h1;
    repeat (4) @(negedge clock);
    srst = 1'h0;
    check({sys, exs, ea, asrc, adiv, pend}, 9'h040);
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // table rows, then back-to-back writes and a mid-run reset
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      write_cfg(rows[i][13:9]);
      settle();
      check({asrc, adiv, ea, pend}, {src, div, src != 2'h1, 1'h0});
      check({8'h00, exs}, {8'h00, ext_hist[2]});
      run_while(1'h1, len);
      run_while(1'h0, len);
      run_while(1'h1, len);
      check(9'(len), rows[i][8:0]);
    end
    // two writes on consecutive edges, strobe held high between them
    @(negedge clock);
    {src, div, cfg_write} = {5'h12, 1'h1};
    @(negedge clock);
    {src, div} = 5'h09;
    @(negedge clock);
    cfg_write = 1'h0;
    settle();
    check({asrc, adiv}, 9'h009);
    write_cfg(5'h07);
    repeat (20) @(negedge clock);
    do_reset();
    give_verdict();
  end
endmodule // test_system_clock_selector
